/* logic/osc_defines.vh */
// constants for oscillator select and rc calibration
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH
`define OSC_CLK_MHZ       25
`define OSC_SLOW_CAL_US   2000
`define OSC_ABORT_US      130
`define OSC_FAST_CAL_CYC  16'h0040
`define OSC_SEL_XTAL      1'h0
`define OSC_SEL_RC        1'h1
`define OSC_PD_RESET      1'h1
`define OSC_MODE_PM0      2'h0
`define OSC_MODE_PM2      2'h2
`define OSC_MODE_PM3      2'h3
`define OSC_DIV_FEC       3'h0
`define OSC_CAL_DEFAULT   8'h80
`define OSC_DIV_BASE      11'h2EE
`define OSC_DIV_USB       11'h5DC
`define OSC_A_CTRL        4'h0
`define OSC_A_MODE        4'h1
`define OSC_A_STAT        4'h2
`define OSC_A_CAL         4'h3
`define OSC_A_CALIN       4'h4
`define OSC_B_SYS         0
`define OSC_B_SLOW        1
`define OSC_B_PD          2
`define OSC_B_DIV_LO      3
`define OSC_B_DIV_HI      5
`define OSC_B_FEC         6
`define OSC_B_IDLE        7
`endif

/* logic/osc_sync3.v */
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module osc_sync3
(
  // clock and reset
  input  wire mclk,
  input  wire reset,
  // raw and filtered level
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // shift chain and agreement of second and third stage
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule
`default_nettype wire

/* logic/osc_timer.v */
// down counter that pulses done when it expires
`timescale 1ns/1ns
`default_nettype none
module osc_timer
#(
  parameter W = 16
)
(
  // clock and reset
  input  wire         mclk,
  input  wire         reset,
  // control
  input  wire         load,
  input  wire         stop,
  input  wire [W-1:0] count,
  // status
  output reg          busy,
  output reg          done
);
  reg [W-1:0] cnt_q;
  // count down from load value, done one cycle at zero
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= {W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (stop)
        busy <= 1'b0;
      else if (load)
      begin
        cnt_q <= count;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

/* logic/osc_ctrl.v */
// oscillator source selection and rc calibration control
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "osc_defines.vh"
module osc_ctrl
#(
  parameter USB_VARIANT = 0,
  parameter SLOW_CAL_US = `OSC_SLOW_CAL_US
)
(
  // clock and reset
  input  wire       mclk,
  input  wire       reset,
  // register port
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // oscillator status pins
  input  wire       xtal_ready_pin,
  input  wire       rc_ready_pin,
  // power mode events
  input  wire       sleep_req,
  input  wire       wake,
  // oscillator enables
  output reg        fast_xtal_osc_en,
  output reg        fast_rc_osc_en,
  output reg        slow_xtal_en,
  output reg        slow_rc_en,
  // clock selects and calibration
  output reg        sys_clk_is_rc,
  output reg        usb_clk_en,
  output reg        slow_clk_is_rc,
  output reg  [7:0] fast_rc_cal,
  output reg        fast_rc_cal_busy,
  output reg        slow_rc_cal_busy,
  output reg [10:0] slow_rc_ratio,
  output reg        sleep_enter
);
  localparam [31:0] SLOW_CAL_CYC = SLOW_CAL_US * `OSC_CLK_MHZ;
  localparam [31:0] ABORT_CYC    = `OSC_ABORT_US * `OSC_CLK_MHZ;
  // slow rc calibration states
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_CAL  = 3'h2;
  localparam [2:0] S_ABRT = 3'h4;

  wire xtal_rdy;
  wire rc_rdy;
  osc_sync3 u_sx (.mclk(mclk), .reset(reset), .din(xtal_ready_pin), .dout(xtal_rdy));
  osc_sync3 u_sr (.mclk(mclk), .reset(reset), .din(rc_ready_pin), .dout(rc_rdy));

  reg        sel_q;
  reg        slow_sel_q;
  reg        pd_q;
  reg        pd_pend_q;
  reg  [2:0] div_q;
  reg        fec_q;
  reg  [1:0] mode_q;
  reg        initial_q;
  reg        fcal_pend_q;
  reg  [7:0] cal_in_q;
  reg  [2:0] st_q;
  reg        hold_q;
  reg        hold_is_sleep_q;
  reg  [1:0] sleep_mode_q;
  reg        asleep_q;          // between sleep entry and wake

  wire xtal_stable_flag   = xtal_rdy & fast_xtal_osc_en;
  wire fast_rc_stable_flag = rc_rdy & fast_rc_osc_en;
  wire any_cal = fast_rc_cal_busy | slow_rc_cal_busy;
  wire ctrl_wr = wr & (addr == `OSC_A_CTRL);
  wire xtal_pd_req = sel_q & pd_q & ~sys_clk_is_rc ? 1'b0 : (sel_q & pd_q);

  // slow calibration timers
  wire slow_done;
  wire abrt_done;
  wire slow_run;
  wire abrt_run;
  wire slow_load = (st_q == S_IDLE) & xtal_stable_flag & ~sys_clk_is_rc & (mode_q == `OSC_MODE_PM0) & ~hold_q
                   & ~asleep_q;
  wire abrt_load = (st_q == S_CAL) & ~initial_q & (hold_q);
  osc_timer #(.W(17)) u_slow (.mclk(mclk), .reset(reset), .load(slow_load),
    .stop(abrt_load | ~xtal_stable_flag), .count(SLOW_CAL_CYC[16:0]), .busy(slow_run), .done(slow_done));
  osc_timer #(.W(17)) u_abrt (.mclk(mclk), .reset(reset), .load(abrt_load),
    .stop(1'b0), .count(ABORT_CYC[16:0]), .busy(abrt_run), .done(abrt_done));
  // fast rc calibration timer
  wire fcal_done;
  wire fcal_run;
  // fast calibration after sleep waits for the return to active mode
  wire fcal_load = fcal_pend_q & ~sys_clk_is_rc & ~fcal_run & (mode_q == `OSC_MODE_PM0) & ~asleep_q;
  osc_timer #(.W(16)) u_fcal (.mclk(mclk), .reset(reset), .load(fcal_load),
    .stop(1'b0), .count(`OSC_FAST_CAL_CYC), .busy(fcal_run), .done(fcal_done));

  // software bits and pending requests
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sel_q        <= `OSC_SEL_RC;
      slow_sel_q   <= 1'b1;
      pd_q         <= `OSC_PD_RESET;
      pd_pend_q    <= 1'b0;
      div_q        <= 3'h0;
      fec_q        <= 1'b0;
      mode_q       <= `OSC_MODE_PM0;
      cal_in_q     <= `OSC_CAL_DEFAULT;
      fcal_pend_q  <= 1'b0;
      sleep_mode_q <= `OSC_MODE_PM0;
      asleep_q     <= 1'b0;
    end
    else
    begin
      if (sleep_enter)
        asleep_q <= 1'b1;
      if (wake)
        asleep_q <= 1'b0;
      if (ctrl_wr)
      begin
        sel_q      <= wdata[`OSC_B_SYS];
        slow_sel_q <= wdata[`OSC_B_SLOW];
        div_q      <= wdata[`OSC_B_DIV_HI:`OSC_B_DIV_LO];
        fec_q      <= wdata[`OSC_B_FEC];
        if (wdata[`OSC_B_SYS] != sel_q)
        begin
          pd_q      <= 1'b0;
          pd_pend_q <= 1'b0;
        end
        else if (wdata[`OSC_B_PD] & any_cal & ~pd_q)
          pd_pend_q <= 1'b1;
        else
          pd_q <= wdata[`OSC_B_PD];
        if (wdata[`OSC_B_SYS] == `OSC_SEL_XTAL && sel_q == `OSC_SEL_RC)
          fcal_pend_q <= 1'b1;
      end
      else if (pd_pend_q & ~any_cal)
      begin
        pd_q      <= 1'b1;
        pd_pend_q <= 1'b0;
      end
      if (wr & (addr == `OSC_A_MODE))
        mode_q <= wdata[1:0];
      if (wr & (addr == `OSC_A_CALIN))
        cal_in_q <= wdata;
      if (fcal_load)
        fcal_pend_q <= 1'b0;
      if (sleep_enter)
      begin
        sleep_mode_q <= mode_q;
        mode_q       <= `OSC_MODE_PM0;
        if (~sel_q)
          fcal_pend_q <= 1'b1;
      end
      if (wake & (sleep_mode_q == `OSC_MODE_PM2 || sleep_mode_q == `OSC_MODE_PM3))
        slow_sel_q <= 1'b1;
    end
  end

  // system clock switch, waits for target stable, and for mode zero only when moving to the crystal
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      sys_clk_is_rc <= 1'b1;
    else if (sel_q != sys_clk_is_rc)
    begin
      if (sel_q & fast_rc_stable_flag)
        sys_clk_is_rc <= 1'b1;
      else if (~sel_q & xtal_stable_flag & (mode_q == `OSC_MODE_PM0))
        sys_clk_is_rc <= 1'b0;
    end
  end

  // fast oscillator power control
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fast_xtal_osc_en <= 1'b0;
      fast_rc_osc_en   <= 1'b1;
      usb_clk_en       <= 1'b0;
    end
    else
    begin
      // crystal kept while calibration or abort delay runs
      fast_xtal_osc_en <= ~sel_q | ~sys_clk_is_rc | ~pd_q | slow_run | abrt_run;
      fast_rc_osc_en   <= sel_q | sys_clk_is_rc | ~pd_q | fcal_run | fcal_pend_q;
      usb_clk_en       <= (USB_VARIANT != 0) & fast_xtal_osc_en & xtal_rdy;
    end
  end

  // fast rc calibration value
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fast_rc_cal      <= `OSC_CAL_DEFAULT;
      fast_rc_cal_busy <= 1'b0;
    end
    else
    begin
      fast_rc_cal_busy <= fcal_run;
      if (wake & (sleep_mode_q == `OSC_MODE_PM2 || sleep_mode_q == `OSC_MODE_PM3))
        fast_rc_cal <= `OSC_CAL_DEFAULT;
      else if (fcal_done)
        fast_rc_cal <= cal_in_q;
    end
  end

  // slow rc calibration with initial and abort handling
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_q             <= S_IDLE;
      initial_q        <= 1'b1;
      hold_q           <= 1'b0;
      hold_is_sleep_q  <= 1'b0;
      sleep_enter      <= 1'b0;
      slow_rc_cal_busy <= 1'b0;
      slow_rc_ratio    <= `OSC_DIV_BASE;
    end
    else
    begin
      sleep_enter      <= 1'b0;
      slow_rc_cal_busy <= slow_run;
      slow_rc_ratio    <= (USB_VARIANT != 0) ? `OSC_DIV_USB : `OSC_DIV_BASE;
      if (~xtal_stable_flag)
        initial_q <= 1'b1;
      if (sleep_req & ~hold_q)
      begin
        hold_q          <= 1'b1;
        hold_is_sleep_q <= 1'b1;
      end
      else if (xtal_pd_req & sys_clk_is_rc & ~hold_q & slow_run)
        hold_q <= 1'b1;
      case (st_q)
        S_IDLE:
        begin
          if (slow_load)
            st_q <= S_CAL;
          else if (hold_q)
          begin
            hold_q          <= 1'b0;
            hold_is_sleep_q <= 1'b0;
            sleep_enter     <= hold_is_sleep_q;
          end
        end
        S_CAL:
        begin
          if (slow_done)
          begin
            initial_q <= 1'b0;
            st_q      <= S_IDLE;
          end
          else if (abrt_load)
            st_q <= S_ABRT;
          else if (~slow_run)
            st_q <= S_IDLE;
        end
        S_ABRT:
        begin
          if (abrt_done)
          begin
            st_q            <= S_IDLE;
            hold_q          <= 1'b0;
            hold_is_sleep_q <= 1'b0;
            sleep_enter     <= hold_is_sleep_q;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // slow oscillator select, only one runs
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      slow_clk_is_rc <= 1'b1;
      slow_rc_en     <= 1'b1;
      slow_xtal_en   <= 1'b0;
    end
    else
    begin
      slow_clk_is_rc <= slow_sel_q;
      slow_rc_en     <= slow_sel_q;
      slow_xtal_en   <= ~slow_sel_q;
    end
  end

  // register read, data one cycle after strobe
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `OSC_A_CTRL:  rdata <= {1'b0, fec_q, div_q, pd_q, slow_sel_q, sel_q};
        `OSC_A_MODE:  rdata <= {6'h00, mode_q};
        `OSC_A_STAT:  rdata <= {2'h0, slow_rc_cal_busy, fast_rc_cal_busy, initial_q,
                                sys_clk_is_rc, fast_rc_stable_flag, xtal_stable_flag};
        `OSC_A_CAL:   rdata <= fast_rc_cal;
        `OSC_A_CALIN: rdata <= cal_in_q;
        default:      rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule
`default_nettype wire

/* tb/osc_ctrl_chk.sv */
// concurrent checks on the oscillator control ports
`timescale 1ns/1ns
`default_nettype none
module osc_ctrl_chk
#(
  parameter USB_VARIANT = 0
)
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // observed pins
  input wire logic        xtal_ready_pin,
  input wire logic        fast_xtal_osc_en,
  input wire logic        fast_rc_osc_en,
  input wire logic        slow_xtal_en,
  input wire logic        slow_rc_en,
  input wire logic        sys_clk_is_rc,
  input wire logic        slow_clk_is_rc,
  input wire logic [7:0]  fast_rc_cal,
  input wire logic        fast_rc_cal_busy,
  input wire logic        slow_rc_cal_busy,
  input wire logic [10:0] slow_rc_ratio
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // system clock moving onto the crystal
  sequence to_xtal;
    $fell(sys_clk_is_rc);
  endsequence
  // properties on selection and calibration
  chk_reset_state: assert property
    ($past(reset) |-> sys_clk_is_rc && slow_clk_is_rc && slow_rc_en && fast_rc_cal == 8'h80)
    else $error("state after reset wrong");
  chk_slow_exclusive: assert property
    (!(slow_xtal_en && slow_rc_en))
    else $error("both slow oscillators on");
  chk_slow_follow: assert property
    ($changed(slow_clk_is_rc) |-> ##[0:4] (slow_rc_en == slow_clk_is_rc))
    else $error("slow oscillator does not follow select");
  chk_rc_runs: assert property
    (sys_clk_is_rc |-> fast_rc_osc_en)
    else $error("system on fast rc while it is off");
  chk_xtal_stable: assert property
    (to_xtal |-> fast_xtal_osc_en && $past(xtal_ready_pin, 3))
    else $error("switch to crystal before it is stable");
  chk_fast_cal_start: assert property
    (to_xtal |-> ##[0:4] fast_rc_cal_busy)
    else $error("no fast rc calibration after switch");
  chk_slow_cal_xtal: assert property
    (slow_rc_cal_busy |-> fast_xtal_osc_en)
    else $error("slow rc calibration without crystal");
  chk_slow_ratio: assert property
    (slow_rc_ratio == (USB_VARIANT != 0 ? 11'h5DC : 11'h2EE))
    else $error("slow rc ratio wrong");
endmodule
bind osc_ctrl osc_ctrl_chk #(.USB_VARIANT(USB_VARIANT)) u_osc_ctrl_chk
(
  .mclk(mclk), .reset(reset), .xtal_ready_pin(xtal_ready_pin), .fast_xtal_osc_en(fast_xtal_osc_en),
  .fast_rc_osc_en(fast_rc_osc_en), .slow_xtal_en(slow_xtal_en), .slow_rc_en(slow_rc_en),
  .sys_clk_is_rc(sys_clk_is_rc), .slow_clk_is_rc(slow_clk_is_rc), .fast_rc_cal(fast_rc_cal),
  .fast_rc_cal_busy(fast_rc_cal_busy), .slow_rc_cal_busy(slow_rc_cal_busy), .slow_rc_ratio(slow_rc_ratio)
);
`default_nettype wire

/* tb/osc_select_and_rc_calibration_bench.sv */
// self-checking bench for oscillator select and rc calibration
`timescale 1ns/1ns
`default_nettype none
`include "osc_defines.vh"
module osc_select_and_rc_calibration_bench;
  // stimulus and observed signals
  logic        mclk, reset, wr, rd, xrdy, rrdy, slp_req, wake;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, cal, d;
  logic        fx_en, fr_en, sx_en, sr_en, sys_rc, usb_en, slow_rc, fbusy, sbusy, slp;
  logic [10:0] ratio;
  int          n_fail, n_checks, n;
  // device under test, short slow calibration
  osc_ctrl #(.SLOW_CAL_US(20)) u_osc_ctrl
  (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .xtal_ready_pin(xrdy), .rc_ready_pin(rrdy), .sleep_req(slp_req), .wake(wake),
    .fast_xtal_osc_en(fx_en), .fast_rc_osc_en(fr_en), .slow_xtal_en(sx_en), .slow_rc_en(sr_en),
    .sys_clk_is_rc(sys_rc), .usb_clk_en(usb_en), .slow_clk_is_rc(slow_rc), .fast_rc_cal(cal),
    .fast_rc_cal_busy(fbusy), .slow_rc_cal_busy(sbusy), .slow_rc_ratio(ratio), .sleep_enter(slp)
  );
  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare tasks for bytes and flags
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
      $display("FAIL %0t byte %h expected %h", $time, g, e);
    if (g !== e)
      n_fail++;
  endtask
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e)
      $display("FAIL %0t flag %b expected %b", $time, g, e);
    if (g !== e)
      n_fail++;
  endtask
  // register bus cycles and event pulses
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic pulse(input logic s);
    @(posedge mclk);
    if (s) slp_req <= 1'b1; else wake <= 1'b1;
    @(posedge mclk);
    slp_req <= 1'b0;
    wake <= 1'b0;
  endtask
  // bounded wait for a level on a chosen output
  task automatic wait_sig(input int s, input logic v, input int lim, output int k);
    logic x;
    k = 0;
    x = ~v;
    while (x !== v && k < lim)
    begin
      @(posedge mclk);
      #1;
      k++;
      case (s)
        0: x = sys_rc;
        1: x = fbusy;
        2: x = sbusy;
        3: x = slp;
        default: x = fr_en;
      endcase
    end
    if (x !== v)
    begin
      n_fail++;
      $display("FAIL %0t wait %0d ran out", $time, s);
      wrap_up();
    end
  endtask
  // reset values, unmapped read, slow source select
  task automatic t_reset;
    rd_reg(`OSC_A_CTRL, d);
    chk8(d & 8'h07, 8'h07);
    rd_reg(`OSC_A_STAT, d);
    chk8(d & 8'h07, 8'h06);
    rd_reg(`OSC_A_CAL, d);
    chk8(d, 8'h80);
    rd_reg(4'hF, d);
    chk8(d, 8'h00);
    chk1(fx_en, 1'b0);
    wr_reg(`OSC_A_CTRL, 8'h05);
    repeat (6) @(posedge mclk);
    chk1(sx_en, 1'b1);
    chk1(sr_en, 1'b0);
    wr_reg(`OSC_A_CTRL, 8'h07);
    repeat (6) @(posedge mclk);
    chk1(sr_en, 1'b1);
    $display("reset test done");
  endtask
  // switch to crystal, fast calibration, deferred power-down
  task automatic t_switch;
    wr_reg(`OSC_A_CALIN, 8'h5A);
    wr_reg(`OSC_A_CTRL, 8'h02);
    repeat (20) @(posedge mclk);
    chk1(sys_rc, 1'b1);
    chk1(fx_en, 1'b1);
    rd_reg(`OSC_A_CTRL, d);
    chk8(d & 8'h07, 8'h02);
    xrdy <= 1'b1;
    wait_sig(0, 1'b0, 20, n);
    chk1(usb_en, 1'b0);
    wait_sig(1, 1'b1, 8, n);
    wait_sig(1, 1'b0, 100, n);
    chk1(n >= 60 && n <= 66, 1'b1);
    chk8(cal, 8'h5A);
    chk1(fr_en, 1'b1);
    rd_reg(`OSC_A_STAT, d);
    chk8(d & 8'h03, 8'h03);
    wait_sig(2, 1'b1, 20, n);
    wr_reg(`OSC_A_CTRL, 8'h06);
    repeat (4) @(posedge mclk);
    rd_reg(`OSC_A_CTRL, d);
    chk8(d & 8'h04, 8'h00);
    wait_sig(4, 1'b0, 600, n);
    chk1(n > 300, 1'b1);
    chk8(cal, 8'h5A);
    $display("switch test done");
  endtask
  // sleep after initial calibration aborts with fixed delay
  task automatic t_abort;
    wait_sig(2, 1'b1, 20, n);
    wr_reg(`OSC_A_MODE, 8'h01);
    pulse(1'b1);
    wait_sig(3, 1'b1, 3400, n);
    chk1(n >= 3240 && n <= 3260, 1'b1);
    chk1(sbusy, 1'b0);
    repeat (80) @(posedge mclk);
    chk1(fbusy, 1'b0);
    pulse(1'b0);
    wait_sig(1, 1'b1, 20, n);
    $display("abort test done");
  endtask
  // second reset: mode blocks switch, sleep waits initial cal
  task automatic t_initial;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    wr_reg(`OSC_A_MODE, 8'h01);
    wr_reg(`OSC_A_CALIN, 8'h3C);
    wr_reg(`OSC_A_CTRL, 8'h02);
    repeat (30) @(posedge mclk);
    chk1(sys_rc, 1'b1);
    wr_reg(`OSC_A_MODE, 8'h02);
    wr_reg(`OSC_A_MODE, 8'h00);
    wait_sig(0, 1'b0, 20, n);
    wait_sig(2, 1'b1, 100, n);
    wr_reg(`OSC_A_MODE, 8'h02);
    pulse(1'b1);
    wait_sig(3, 1'b1, 600, n);
    chk1(n > 300, 1'b1);
    chk1(sbusy, 1'b0);
    chk8(cal, 8'h3C);
    pulse(1'b0);
    rd_reg(`OSC_A_CAL, d);
    chk8(d, 8'h80);
    $display("initial calibration test done");
  endtask
  // main sequence
  initial
  begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    xrdy = 1'b0;
    rrdy = 1'b1;
    slp_req = 1'b0;
    wake = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    t_reset();
    t_switch();
    t_abort();
    t_initial();
    wrap_up();
  end
endmodule
`default_nettype wire
